// File: core/ewrbh_core.sv
// External interface write-ready sequencing and bus-hold arbitration.
// Summary of operation
// - Synchronous ready: first sample at write lead plus write active cycles.
// - Synchronous: ready high ends access; low resamples every timing cycle.
// - Asynchronous ready: first sample two cycles earlier than synchronous.
// - Every access lead starts on a rising edge of the bus clock.
// - Alignment cycles keep all strobes and selects inactive.
// - Address bus keeps the last address during inactive cycles.
// - Hold mode set during a grant releases acknowledge and drives the bus.
// - Reset clears the hold-mode bit.
// - Hold request low during reset floats the bus, acknowledge low.
// - Accesses during a grant stall until hold request is released.
// - Grant floats address, data, strobes, read-not-write and zone selects.
// - Bus clock and other signals keep working during a grant.
// - Hold request level is registered on every rising timing clock edge.
// - Pending accesses finish before the bus floats and is acknowledged.
`timescale 1ns/1ps
`default_nettype none
module ewrbh_core
    import ewrbh_pkg::*;
#(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 16
) (
    // System clock and reset.
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    // Interface timing clock.
    input  wire logic              iface_timing_clock_i,
    // Register port.
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_write_i,
    input  wire logic              reg_read_i,
    output logic      [31:0]       reg_rdata_o,
    // Processor access request.
    input  wire logic              cpu_req_i,
    input  wire logic              cpu_write_i,
    input  wire logic [1:0]        cpu_zone_i,
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    input  wire logic [DATA_W-1:0] cpu_wdata_i,
    output logic                   cpu_stall_o,
    output logic                   cpu_done_o,
    output logic      [DATA_W-1:0] cpu_rdata_o,
    // External memory pins.
    output logic      [ADDR_W-1:0] ext_address_bus_o,
    output logic                   ext_address_bus_oe_o,
    input  wire logic [DATA_W-1:0] ext_data_bus_i,
    output logic      [DATA_W-1:0] ext_data_bus_o,
    output logic                   ext_data_bus_oe_o,
    output logic                   write_strobe_n_o,
    output logic                   read_strobe_n_o,
    output logic                   read_not_write_o,
    output logic                   zone_a_select_n_o,
    output logic                   zone_b_select_n_o,
    output logic                   zone_c_select_n_o,
    output logic                   ctrl_oe_o,
    input  wire logic              ext_ready_i,
    output logic                   bus_clock_out_o,
    // Bus hold pins.
    input  wire logic              bus_hold_req_n_i,
    output logic                   bus_hold_ack_n_o
);

    initial begin
        if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 32) begin
            $error("ewrbh_core: ADDR_W and DATA_W must lie in 1..32.");
        end
    end

    logic [EWRBH_CFG_W-1:0] cfg_reg;
    logic [EWRBH_CFG_W-1:0] cfg_next;
    logic [31:0]            rdata_reg;
    logic [31:0]            rdata_next;
    logic                   busy_reg;
    logic                   req_tog_reg;
    logic                   cpu_write_reg;
    logic [1:0]             cpu_zone_reg;
    logic [ADDR_W-1:0]      cpu_addr_reg;
    logic [DATA_W-1:0]      cpu_wdata_reg;
    logic                   done_seen_reg;
    logic                   done_pulse_reg;
    logic [DATA_W-1:0]      cpu_rdata_reg;
    logic                   done_tog_s;
    logic                   grant_s;
    logic                   hreq_s;
    logic                   hreq_t;
    logic                   grant_t;
    logic                   done_tog_reg;

    wire sel_cfg    = (reg_addr_i == EWRBH_CFG_OFFSET);
    wire sel_status = (reg_addr_i == EWRBH_STATUS_OFFSET);
    wire done_evt   = (done_tog_s != done_seen_reg);
    wire accept     = cpu_req_i && !busy_reg;

    wire [31:0] status_word = {29'h0000000, hreq_s, grant_s, busy_reg};

    assign cfg_next   = (reg_write_i && sel_cfg) ?
                        reg_wdata_i[EWRBH_CFG_W-1:0] : cfg_reg;
    assign rdata_next = !reg_read_i ? 32'h00000000 :
                        sel_cfg     ? {22'h000000, cfg_reg} :
                        sel_status  ? status_word : 32'h00000000;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_reg   <= EWRBH_CFG_RESET;
            rdata_reg <= 32'h00000000;
        end else begin
            cfg_reg   <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    // Request fields stay frozen while busy, so the timing side may read them.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_write_reg <= 1'b0;
            cpu_zone_reg  <= EWRBH_ZONE_A;
            cpu_addr_reg  <= '0;
            cpu_wdata_reg <= '0;
        end else if (accept) begin
            cpu_write_reg <= cpu_write_i;
            cpu_zone_reg  <= cpu_zone_i;
            cpu_addr_reg  <= cpu_addr_i;
            cpu_wdata_reg <= cpu_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_reg       <= 1'b0;
            req_tog_reg    <= 1'b0;
            done_seen_reg  <= 1'b0;
            done_pulse_reg <= 1'b0;
        end else begin
            busy_reg       <= accept || (busy_reg && !done_evt);
            req_tog_reg    <= req_tog_reg ^ accept;
            done_seen_reg  <= done_tog_s;
            done_pulse_reg <= done_evt;
        end
    end

    ewrbh_sync #(.WIDTH(3), .RST_VAL(3'b100)) u_sync_to_sys (
        .clk_i     (sys_clk_i),
        .reset_n_i (reset_n_i),
        .d_i       ({hreq_t, grant_t, done_tog_reg}),
        .q_o       ({hreq_s, grant_s, done_tog_s})
    );

    logic                   rst_t_n;
    logic [EWRBH_CFG_W-1:0] cfg_t;
    logic                   ready_t;
    logic                   req_tog_t;

    ewrbh_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk_i     (iface_timing_clock_i),
        .reset_n_i (reset_n_i),
        .d_i       (1'b1),
        .q_o       (rst_t_n)
    );

    // The hold request resets low, so a grant held through reset is kept.
    ewrbh_sync #(.WIDTH(EWRBH_CFG_W + 3), .RST_VAL({EWRBH_CFG_RESET, 3'b000}))
    u_sync_to_tim (
        .clk_i     (iface_timing_clock_i),
        .reset_n_i (rst_t_n),
        .d_i       ({cfg_reg, ext_ready_i, bus_hold_req_n_i, req_tog_reg}),
        .q_o       ({cfg_t, ready_t, hreq_t, req_tog_t})
    );

    ewrbh_state_t           state_reg;
    ewrbh_state_t           state_next;
    logic [EWRBH_CNT_W-1:0] cnt_reg;
    logic [EWRBH_CNT_W-1:0] cnt_next;
    logic                   ready_seen_reg;
    logic                   ready_seen_next;
    logic                   req_seen_reg;
    logic                   bclk_reg;
    logic                   acc_write_reg;
    logic [1:0]             acc_zone_reg;
    logic [ADDR_W-1:0]      addr_reg;
    logic [DATA_W-1:0]      wdata_reg;
    logic [DATA_W-1:0]      rd_cap_reg;
    logic                   wr_n_reg;
    logic                   rd_n_reg;
    logic                   rnw_reg;
    logic [2:0]             zsel_n_reg;
    logic                   bus_oe_reg;
    logic                   data_oe_reg;
    logic                   ack_n_reg;

    // Zero counts act as one so that every period lasts at least a cycle.
    wire [EWRBH_CNT_W-1:0] lead_c = (cfg_t[EWRBH_CFG_LEAD_LSB +: EWRBH_LEAD_W]
        == '0) ? 8'h01 : {6'h00, cfg_t[EWRBH_CFG_LEAD_LSB +: EWRBH_LEAD_W]};
    wire [EWRBH_CNT_W-1:0] act_c = (cfg_t[EWRBH_CFG_ACTIVE_LSB +: EWRBH_ACTIVE_W]
        == '0) ? 8'h01 : {5'h00, cfg_t[EWRBH_CFG_ACTIVE_LSB +: EWRBH_ACTIVE_W]};
    wire [EWRBH_CNT_W-1:0] trail_c = (cfg_t[EWRBH_CFG_TRAIL_LSB +: EWRBH_TRAIL_W]
        == '0) ? 8'h01 : {6'h00, cfg_t[EWRBH_CFG_TRAIL_LSB +: EWRBH_TRAIL_W]};
    wire                   rdy_en    = cfg_t[EWRBH_CFG_RDY_EN_BIT];
    wire                   rdy_async = cfg_t[EWRBH_CFG_RDY_MD_BIT];
    wire                   hold_mode = cfg_t[EWRBH_CFG_HOLD_BIT];

    wire [EWRBH_CNT_W-1:0] lead_act = lead_c + act_c;
    wire [EWRBH_CNT_W-1:0] sample_pt = rdy_async ?
                           lead_act - EWRBH_ASYNC_ADVANCE : lead_act;
    wire sample_now = rdy_en && (cnt_reg >= sample_pt);
    wire ready_ok   = !rdy_en || ready_seen_reg ||
                      (sample_now && ready_t);
    wire pending    = (req_tog_t != req_seen_reg);
    wire grant_want = !hreq_t && !hold_mode;
    wire cnt_inc_sat = (cnt_reg == 8'hff);
    wire [EWRBH_CNT_W-1:0] cnt_inc = cnt_inc_sat ? cnt_reg : cnt_reg + 8'h01;
    wire in_access = state_next inside {EWRBH_LEAD, EWRBH_ACTIVE, EWRBH_TRAIL};
    wire start_acc  = (state_next == EWRBH_LEAD) && (state_reg != EWRBH_LEAD);
    wire end_active = (state_reg == EWRBH_ACTIVE) &&
                      (state_next == EWRBH_TRAIL);
    wire end_acc    = (state_reg == EWRBH_TRAIL) &&
                      (state_next == EWRBH_IDLE);

    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_inc;
        ready_seen_next = ready_seen_reg;
        case (state_reg)
            EWRBH_IDLE: begin
                cnt_next = '0;
                if (pending) begin
                    // A high bus clock now means the next edge is falling.
                    state_next = bclk_reg ? EWRBH_ALIGN : EWRBH_LEAD;
                end else if (grant_want) begin
                    state_next = EWRBH_HELD;
                end
            end
            EWRBH_ALIGN: begin
                cnt_next   = '0;
                state_next = EWRBH_LEAD;
            end
            EWRBH_LEAD: begin
                ready_seen_next = 1'b0;
                if (cnt_reg >= lead_c - 8'h01) begin
                    state_next = EWRBH_ACTIVE;
                end
            end
            EWRBH_ACTIVE: begin
                if (sample_now && ready_t) begin
                    ready_seen_next = 1'b1;
                end
                if ((cnt_reg >= lead_act - 8'h01) && ready_ok) begin
                    state_next = EWRBH_TRAIL;
                    cnt_next   = '0;
                end
            end
            EWRBH_TRAIL: begin
                if (cnt_reg >= trail_c - 8'h01) begin
                    state_next = EWRBH_IDLE;
                end
            end
            EWRBH_HELD: begin
                cnt_next = '0;
                if (hreq_t || hold_mode) begin
                    state_next = EWRBH_IDLE;
                end
            end
            default: begin
                state_next = EWRBH_IDLE;
            end
        endcase
    end

    always_ff @(posedge iface_timing_clock_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            state_reg      <= EWRBH_HELD;
            cnt_reg        <= '0;
            ready_seen_reg <= 1'b0;
            bclk_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            ready_seen_reg <= ready_seen_next;
            bclk_reg       <= !bclk_reg;
        end
    end

    always_ff @(posedge iface_timing_clock_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            req_seen_reg  <= 1'b0;
            done_tog_reg  <= 1'b0;
            acc_write_reg <= 1'b0;
            acc_zone_reg  <= EWRBH_ZONE_A;
            addr_reg      <= '0;
            wdata_reg     <= '0;
            rd_cap_reg    <= '0;
        end else begin
            if (start_acc) begin
                req_seen_reg  <= req_tog_t;
                acc_write_reg <= cpu_write_reg;
                acc_zone_reg  <= cpu_zone_reg;
                addr_reg      <= cpu_addr_reg;
                wdata_reg     <= cpu_wdata_reg;
            end
            if (end_active) begin
                rd_cap_reg <= ext_data_bus_i;
            end
            done_tog_reg <= done_tog_reg ^ end_acc;
        end
    end

    wire strobe_on = (state_next == EWRBH_ACTIVE);
    wire zone_on   = in_access;
    wire wr_acc    = start_acc ? cpu_write_reg : acc_write_reg;
    wire [1:0] zone_acc = start_acc ? cpu_zone_reg : acc_zone_reg;

    always_ff @(posedge iface_timing_clock_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            wr_n_reg    <= 1'b1;
            rd_n_reg    <= 1'b1;
            rnw_reg     <= 1'b1;
            zsel_n_reg  <= 3'h7;
            bus_oe_reg  <= 1'b0;
            data_oe_reg <= 1'b0;
            ack_n_reg   <= 1'b0;
        end else begin
            wr_n_reg      <= !(strobe_on && wr_acc);
            rd_n_reg      <= !(strobe_on && !wr_acc);
            rnw_reg       <= !(zone_on && wr_acc);
            zsel_n_reg[0] <= !(zone_on && zone_acc == EWRBH_ZONE_A);
            zsel_n_reg[1] <= !(zone_on && zone_acc == EWRBH_ZONE_B);
            zsel_n_reg[2] <= !(zone_on && zone_acc == EWRBH_ZONE_C);
            bus_oe_reg    <= (state_next != EWRBH_HELD);
            data_oe_reg   <= zone_on && wr_acc;
            ack_n_reg     <= (state_next != EWRBH_HELD);
        end
    end

    assign grant_t = !ack_n_reg;

    assign reg_rdata_o          = rdata_reg;
    assign cpu_stall_o          = busy_reg;
    assign cpu_done_o           = done_pulse_reg;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_rdata_reg <= '0;
        end else if (done_evt) begin
            cpu_rdata_reg <= rd_cap_reg;
        end
    end
    assign cpu_rdata_o          = cpu_rdata_reg;

    assign ext_address_bus_o    = addr_reg;
    assign ext_address_bus_oe_o = bus_oe_reg;
    assign ext_data_bus_o       = wdata_reg;
    assign ext_data_bus_oe_o    = data_oe_reg && bus_oe_reg;
    assign write_strobe_n_o     = wr_n_reg;
    assign read_strobe_n_o      = rd_n_reg;
    assign read_not_write_o     = rnw_reg;
    assign zone_a_select_n_o    = zsel_n_reg[0];
    assign zone_b_select_n_o    = zsel_n_reg[1];
    assign zone_c_select_n_o    = zsel_n_reg[2];
    assign ctrl_oe_o            = bus_oe_reg;
    assign bus_clock_out_o      = bclk_reg;

    // While reset is held the acknowledge mirrors the request pin.
    assign bus_hold_ack_n_o = rst_t_n ? ack_n_reg : bus_hold_req_n_i;
endmodule : ewrbh_core
`default_nettype wire

// File: core/ewrbh_pkg.sv
// Shared constants and types of the external write-ready and bus-hold block.
package ewrbh_pkg;

    // Register offsets on the software port.
    localparam logic [3:0] EWRBH_CFG_OFFSET    = 4'h0;
    localparam logic [3:0] EWRBH_STATUS_OFFSET = 4'h4;

    // Field widths and positions of the configuration register.
    localparam int         EWRBH_LEAD_W         = 2;
    localparam int         EWRBH_ACTIVE_W       = 3;
    localparam int         EWRBH_TRAIL_W        = 2;
    localparam int         EWRBH_CFG_W          = 10;
    localparam int         EWRBH_CFG_LEAD_LSB   = 0;
    localparam int         EWRBH_CFG_ACTIVE_LSB = 2;
    localparam int         EWRBH_CFG_TRAIL_LSB  = 5;
    localparam int         EWRBH_CFG_RDY_EN_BIT = 7;
    localparam int         EWRBH_CFG_RDY_MD_BIT = 8;
    localparam int         EWRBH_CFG_HOLD_BIT   = 9;
    // Lead 1, active 3, trail 1, ready off, synchronous mode, hold mode 0.
    localparam logic [9:0] EWRBH_CFG_RESET      = 10'h02d;

    // Status register bit positions.
    localparam int EWRBH_STAT_BUSY_BIT  = 0;
    localparam int EWRBH_STAT_GRANT_BIT = 1;
    localparam int EWRBH_STAT_HREQ_BIT  = 2;

    // Width of the elapsed-cycle counter of one access.
    localparam int         EWRBH_CNT_W         = 8;
    // Asynchronous ready is sampled this many cycles before synchronous.
    localparam logic [7:0] EWRBH_ASYNC_ADVANCE = 8'h02;

    // Zone codes on the request port.
    localparam logic [1:0] EWRBH_ZONE_A = 2'h0;
    localparam logic [1:0] EWRBH_ZONE_B = 2'h1;
    localparam logic [1:0] EWRBH_ZONE_C = 2'h2;

    typedef enum logic [2:0] {
        EWRBH_IDLE,
        EWRBH_ALIGN,
        EWRBH_LEAD,
        EWRBH_ACTIVE,
        EWRBH_TRAIL,
        EWRBH_HELD
    } ewrbh_state_t;

endpackage : ewrbh_pkg

// File: core/ewrbh_sync.sv
// Two-stage synchroniser for a vector of levels, with a constant reset value.
`timescale 1ns/1ps
`default_nettype none
module ewrbh_sync #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset of the receiving domain.
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Level from the other domain and its synchronised copy.
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("ewrbh_sync: WIDTH must be at least one.");
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule : ewrbh_sync
`default_nettype wire

// File: verification/ewrbh_core_sva.sv
// Concurrent checks of the pin-side sequencing and bus-hold behaviour.
`timescale 1ns/1ps
`default_nettype none
module ewrbh_core_sva #(
    parameter int ADDR_W = 19
) (
    // Timing clock and reset.
    input wire logic              iface_timing_clock_i,
    input wire logic              reset_n_i,
    // Watched pins of the external interface.
    input wire logic [ADDR_W-1:0] ext_address_bus_o,
    input wire logic              ext_address_bus_oe_o,
    input wire logic              ext_data_bus_oe_o,
    input wire logic              write_strobe_n_o,
    input wire logic              read_strobe_n_o,
    input wire logic              zone_a_select_n_o,
    input wire logic              zone_b_select_n_o,
    input wire logic              zone_c_select_n_o,
    input wire logic              ctrl_oe_o,
    input wire logic              bus_clock_out_o,
    input wire logic              bus_hold_req_n_i,
    input wire logic              bus_hold_ack_n_o
);
    logic [3:0] run_reg;
    wire logic  run_ok   = run_reg[3];
    wire logic  sel_idle = zone_a_select_n_o & zone_b_select_n_o &
                           zone_c_select_n_o;

    // The ack-fall, ack-release and bus-clock checks wait until the release has settled.
    always_ff @(posedge iface_timing_clock_i or negedge reset_n_i) begin
        if (!reset_n_i)
            run_reg <= 4'h0;
        else if (!run_ok)
            run_reg <= run_reg + 4'h1;
    end

    default clocking @(posedge iface_timing_clock_i); endclocking
    default disable iff (!reset_n_i);

    property p_hold_float;
        !bus_hold_ack_n_o |->
            !ext_address_bus_oe_o && !ext_data_bus_oe_o && !ctrl_oe_o;
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("bus driven during grant");
    property p_grant_idle;
        !bus_hold_ack_n_o |-> sel_idle && write_strobe_n_o && read_strobe_n_o;
    endproperty
    a_grant_idle: assert property (p_grant_idle)
        else $error("access during grant");
    property p_ack_fall;
        run_ok && $fell(bus_hold_ack_n_o) |-> !$past(bus_hold_req_n_i, 3);
    endproperty
    a_ack_fall: assert property (p_ack_fall)
        else $error("grant without request");
    property p_ack_release;
        run_ok && bus_hold_req_n_i [*8] |-> bus_hold_ack_n_o;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("grant kept after release");
    property p_align;
        $fell(sel_idle) |-> $rose(bus_clock_out_o);
    endproperty
    a_align: assert property (p_align)
        else $error("lead not on bus clock rise");
    property p_strobe_sel;
        !(write_strobe_n_o && read_strobe_n_o) |-> !sel_idle;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel)
        else $error("strobe outside access");
    property p_addr_hold;
        sel_idle && $past(sel_idle) && ext_address_bus_oe_o &&
            $past(ext_address_bus_oe_o) |-> $stable(ext_address_bus_o);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved while inactive");
    property p_clk_runs;
        run_ok |-> bus_clock_out_o != $past(bus_clock_out_o);
    endproperty
    a_clk_runs: assert property (p_clk_runs)
        else $error("bus clock stopped");
endmodule : ewrbh_core_sva

bind ewrbh_core ewrbh_core_sva #(.ADDR_W(ADDR_W)) i_ewrbh_core_sva (.*);
`default_nettype wire

// File: verification/ewrbh_ext_mem.sv
// Behavioural external memory with a ready line, beyond the pins.
`timescale 1ns/1ps
`default_nettype none
module ewrbh_ext_mem (
    // Timing clock and pins from the interface.
    input  wire logic        clk_i,
    input  wire logic [18:0] addr_i,
    input  wire logic [15:0] data_i,
    input  wire logic        data_oe_i,
    input  wire logic        wr_n_i,
    input  wire logic        rd_n_i,
    input  wire logic [2:0]  sel_n_i,
    // Wait cycles wanted on each access.
    input  wire logic [7:0]  wait_i,
    // Pins driven by the memory.
    output logic             ready_o,
    output logic      [15:0] data_o
);
    logic [15:0] mem [16];
    logic [15:0] last_reg = 16'h0000;
    logic [7:0]  cnt_reg  = 8'h00;
    wire logic   sel      = ~&sel_n_i;

    always_ff @(posedge clk_i) begin
        cnt_reg <= sel ? cnt_reg + 8'h01 : 8'h00;
        if (!wr_n_i && data_oe_i)
            mem[addr_i[3:0]] <= data_i;
        if (!rd_n_i)
            last_reg <= mem[addr_i[3:0]];
    end

    // The ready line has a pull-up, so it reads high outside accesses.
    assign ready_o = !(sel && cnt_reg < wait_i);
    // A released data bus shows the inverse of the last value.
    assign data_o  = !rd_n_i ? mem[addr_i[3:0]] : ~last_reg;
endmodule : ewrbh_ext_mem
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench of the write-ready and bus-hold block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ewrbh_pkg::*;
;
    logic        sys_clk_i            = 1'b0;
    logic        iface_timing_clock_i = 1'b0;
    logic        reset_n_i            = 1'b0;
    logic [3:0]  reg_addr_i           = 4'h0;
    logic [31:0] reg_wdata_i          = 32'h0;
    logic        reg_write_i          = 1'b0;
    logic        reg_read_i           = 1'b0;
    logic        cpu_req_i            = 1'b0;
    logic        cpu_write_i          = 1'b0;
    logic [1:0]  cpu_zone_i           = 2'h0;
    logic [18:0] cpu_addr_i           = 19'h0;
    logic [15:0] cpu_wdata_i          = 16'h0;
    logic        bus_hold_req_n_i     = 1'b0;
    logic [7:0]  wait_cyc             = 8'h00;
    logic [31:0] reg_rdata_o, r;
    logic [15:0] cpu_rdata_o, ext_data_bus_o, mem_data;
    logic [18:0] ext_address_bus_o;
    logic        cpu_stall_o, cpu_done_o, ext_address_bus_oe_o, ctrl_oe_o;
    logic        ext_data_bus_oe_o, write_strobe_n_o, read_strobe_n_o;
    logic        read_not_write_o, zone_a_select_n_o, zone_b_select_n_o;
    logic        zone_c_select_n_o, ext_ready_i, bus_clock_out_o;
    logic        bus_hold_ack_n_o;
    int unsigned error_cnt = 0, compares = 0, done_cnt = 0, run = 0, len = 0;
    int unsigned n;
    // Strobe-low cycles expected of each mode.
    logic [9:0]  mode [3]    = '{10'h02d, 10'h0ad, 10'h1ad};
    int unsigned exp_len [3] = '{3, 4, 3};
    wire logic [15:0] ext_data_bus_i = ext_data_bus_oe_o ? ext_data_bus_o
                                                         : mem_data;
    wire logic [2:0]  sel_pin = ctrl_oe_o ? {zone_a_select_n_o,
        zone_b_select_n_o, zone_c_select_n_o} : 3'h7;

    ewrbh_core i_ewrbh_core (.*);
    ewrbh_ext_mem i_ewrbh_ext_mem (
        .clk_i(iface_timing_clock_i), .addr_i(ext_address_bus_o),
        .data_i(ext_data_bus_o), .data_oe_i(ext_data_bus_oe_o),
        .wr_n_i(!ctrl_oe_o | write_strobe_n_o),
        .rd_n_i(!ctrl_oe_o | read_strobe_n_o), .sel_n_i(sel_pin),
        .wait_i(wait_cyc), .ready_o(ext_ready_i), .data_o(mem_data)
    );

    always #20 sys_clk_i = ~sys_clk_i;
    always #24 iface_timing_clock_i = ~iface_timing_clock_i;
    always @(posedge sys_clk_i) if (cpu_done_o === 1'b1) done_cnt++;
    // Length of the last strobe-low stretch in timing cycles.
    always @(posedge iface_timing_clock_i) begin
        if ((write_strobe_n_o & read_strobe_n_o) === 1'b0)
            run++;
        else if (run != 0) begin
            len = run;
            run = 0;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_write_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_read_i <= 1'b0;
        @(posedge sys_clk_i);
        d = reg_rdata_o;
    endtask : reg_rd
    task automatic cpu_go(input logic w, input logic [1:0] z,
                          input logic [18:0] a, input logic [15:0] d);
        n = done_cnt;
        cpu_req_i   <= 1'b1;
        cpu_write_i <= w;
        cpu_zone_i  <= z;
        cpu_addr_i  <= a;
        cpu_wdata_i <= d;
        @(posedge sys_clk_i);
        cpu_req_i   <= 1'b0;
    endtask : cpu_go
    task automatic cpu_end();
        for (int i = 0; i < 200 && done_cnt == n; i++)
            @(posedge sys_clk_i);
        chk(done_cnt != n, 1'b1);
        @(posedge sys_clk_i);
    endtask : cpu_end
    task automatic wait_ack(input logic v);
        for (int i = 0; i < 60 && bus_hold_ack_n_o !== v; i++)
            @(posedge sys_clk_i);
    endtask : wait_ack
    task automatic finish_test();
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial begin
        #300000;
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge sys_clk_i);
        chk(bus_hold_ack_n_o, 1'b0);
        chk({ext_address_bus_oe_o, ext_data_bus_oe_o, ctrl_oe_o}, 3'h0);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd(EWRBH_CFG_OFFSET, r);
        chk(r, 32'(EWRBH_CFG_RESET));
        reg_wr(4'h8, 32'h3ff);
        reg_rd(4'h8, r);
        chk(r, 32'h0);
        repeat (20) @(posedge sys_clk_i);
        chk(bus_hold_ack_n_o, 1'b0);
        reg_wr(EWRBH_CFG_OFFSET, 32'h22d);
        wait_ack(1'b1);
        chk({bus_hold_ack_n_o, ctrl_oe_o}, 2'h3);
        reg_wr(EWRBH_CFG_OFFSET, 32'h02d);
        wait_ack(1'b0);
        chk({bus_hold_ack_n_o, ctrl_oe_o}, 2'h0);
        cpu_go(1'b1, EWRBH_ZONE_A, 19'h00005, 16'h5a5a);
        repeat (40) @(posedge sys_clk_i);
        chk({cpu_stall_o, done_cnt == n, ctrl_oe_o}, 3'h6);
        bus_hold_req_n_i <= 1'b1;
        wait_ack(1'b1);
        chk({bus_hold_ack_n_o, ctrl_oe_o}, 2'h3);
        cpu_end();
        chk(done_cnt, n + 1);
        foreach (mode[i]) begin
            reg_wr(EWRBH_CFG_OFFSET, 32'(mode[i]));
            cpu_go(1'b1, 2'(i), 19'(16 + i), 16'(16'h1230 + i));
            cpu_end();
            chk(len, exp_len[i]);
            cpu_go(1'b0, 2'(i), 19'(16 + i), 16'h0000);
            cpu_end();
            chk(cpu_rdata_o, 16'(16'h1230 + i));
        end
        wait_cyc <= 8'h0a;
        for (int i = 1; i < 3; i++) begin
            reg_wr(EWRBH_CFG_OFFSET, 32'(mode[i]));
            cpu_go(1'b1, EWRBH_ZONE_B, 19'h00021, 16'h0f0f);
            cpu_end();
            chk(len >= 10, 1'b1);
        end
        wait_cyc <= 8'h00;
        cpu_go(1'b1, EWRBH_ZONE_C, 19'h00030, 16'hc3c3);
        bus_hold_req_n_i <= 1'b0;
        wait_ack(1'b0);
        chk(i_ewrbh_ext_mem.mem[0], 16'hc3c3);
        bus_hold_req_n_i <= 1'b1;
        wait_ack(1'b1);
        chk(bus_hold_ack_n_o, 1'b1);
        cpu_end();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
